// ---- hdl/rpo_top.sv ----
/*
 Test access around the macrocell registers: preload from pins, buried
 register observe, power-up clear and the security fuse lockout.
 Assumes the supervoltage detectors arrive as logic levels from pins,
 and the functional next-state values come from the logic array.
*/
`timescale 1ns/1ps
`include "rpo_consts.svh"
module rpo_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Test pins
	input wire logic special_mode_lead,
	input wire logic observe_mode_lead,
	input wire logic preload_strobe,
	input wire logic bank_select,
	input wire logic parity_select,
	input wire rpo_pkg::rpo_cells_t io_pin_in,
	input wire logic security_fuse,
	// Functional register path
	input wire logic func_clk_en,
	input wire rpo_pkg::rpo_cells_t first_register_d,
	input wire rpo_pkg::rpo_cells_t buried_second_register_d,
	input wire rpo_pkg::rpo_cells_t out_polarity_high,
	input wire rpo_pkg::rpo_cells_t out_enable_in,
	// Verify read
	input wire rpo_pkg::rpo_verify_t verify_data_in,
	output rpo_pkg::rpo_verify_t verify_data_out,
	// Outputs
	output rpo_pkg::rpo_cells_t io_pin_out,
	output rpo_pkg::rpo_cells_t io_pin_oe,
	output rpo_pkg::rpo_cells_t first_register,
	output rpo_pkg::rpo_cells_t buried_second_register,
	output logic preload_active,
	output logic clear_busy
);
	import rpo_pkg::*;

	localparam int NG = `RPO_NUM_GROUP;

	logic smp_s, obs_s, strobe_s, bank_s, par_s, fuse_s;
	rpo_cells_t pin_s, pol_s, oe_s;
	logic strobe_prev_reg;
	logic [`RPO_PR_CNT_W-1:0] clr_cnt_reg;
	rpo_mode_t mode_reg, mode_next;
	logic load_pulse;

	// Spread a 12-bit group over the even or odd cells
	function automatic rpo_cells_t spread(input rpo_group_t g,
		input logic odd);
		rpo_cells_t r;
		r = '0;
		for (int i = 0; i < NG; i++) begin
			r[2*i + int'(odd)] = g[i];
		end
		return r;
	endfunction

	// Collect the odd cell pin levels as preload data
	function automatic rpo_group_t odd_pins(input rpo_cells_t p);
		rpo_group_t r;
		r = '0;
		for (int i = 0; i < NG; i++) begin
			r[i] = p[2*i + 1];
		end
		return r;
	endfunction

	// Pin level synchronisers
	rpo_sync #(.WIDTH(6 + 3 * `RPO_NUM_CELLS)) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.async_in({special_mode_lead, observe_mode_lead, preload_strobe,
			bank_select, parity_select, security_fuse, io_pin_in,
			out_polarity_high, out_enable_in}),
		.sync_out({smp_s, obs_s, strobe_s, bank_s, par_s, fuse_s, pin_s,
			pol_s, oe_s})
	);

	// Power-up clear interval counter
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clr_cnt_reg <= '0;
		end else if (clk_en && mode_reg == RPO_CLEAR) begin
			clr_cnt_reg <= clr_cnt_reg + 1'b1; // RULE6
		end
	end

	// Mode selection; fuse blocks both test modes
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			RPO_CLEAR: begin
				if (clr_cnt_reg == `RPO_CNT_LAST)
					mode_next = RPO_RUN;
			end
			RPO_RUN, RPO_PRELOAD, RPO_OBSERVE: begin
				if (smp_s && !fuse_s)
					mode_next = RPO_PRELOAD; // RULE2 RULE11
				else if (obs_s && !fuse_s)
					mode_next = RPO_OBSERVE; // RULE5 RULE11
				else
					mode_next = RPO_RUN;
			end
			default: mode_next = RPO_CLEAR;
		endcase
	end

	// Mode register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			mode_reg <= RPO_CLEAR;
		else if (clk_en)
			mode_reg <= mode_next;
	end

	// Strobe edge detector on the synchronised strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			strobe_prev_reg <= 1'b0;
		else if (clk_en)
			strobe_prev_reg <= strobe_s;
	end

	// Load only on a rising strobe in preload state
	assign load_pulse = mode_reg == RPO_PRELOAD && strobe_s &&
		!strobe_prev_reg && !fuse_s; // RULE14 RULE3

	// First register bank
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			first_register <= '0;
		end else if (clk_en) begin
			if (mode_reg == RPO_CLEAR) begin
				first_register <= '0; // RULE6
			end else if (load_pulse) begin
				if (!bank_s) begin
					// Selected half from odd pins, the rest held
					first_register <= (first_register &
						~spread('1, par_s)) |
						spread(odd_pins(pin_s), par_s); // RULE1 RULE4 RULE13
				end
			end else if (func_clk_en && mode_reg == RPO_RUN) begin
				first_register <= first_register_d;
			end
		end
	end

	// Buried second register bank
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			buried_second_register <= '0;
		end else if (clk_en) begin
			if (mode_reg == RPO_CLEAR) begin
				buried_second_register <= '0; // RULE6
			end else if (load_pulse) begin
				if (bank_s) begin
					buried_second_register <= (buried_second_register &
						~spread('1, par_s)) |
						spread(odd_pins(pin_s), par_s); // RULE1 RULE4 RULE13
				end
			end else if (func_clk_en && mode_reg == RPO_RUN) begin
				buried_second_register <= buried_second_register_d;
			end
		end
	end

	// Output pins: polarity applied, or buried bank shown in observe mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			io_pin_out <= '0;
			io_pin_oe <= '0;
		end else if (clk_en) begin
			io_pin_oe <= (mode_reg == RPO_PRELOAD) ? '0 : oe_s;
			if (mode_reg == RPO_OBSERVE)
				io_pin_out <= buried_second_register; // RULE5
			else
				io_pin_out <= ~(first_register ^ pol_s); // RULE7
		end
	end

	// Verify reads forced to programmed once the fuse is set
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			verify_data_out <= `RPO_VERIFY_PROGRAMMED;
		else if (clk_en)
			verify_data_out <= fuse_s ? `RPO_VERIFY_PROGRAMMED :
				verify_data_in; // RULE10
	end

	// Status flags
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			preload_active <= 1'b0;
			clear_busy <= 1'b1;
		end else if (clk_en) begin
			preload_active <= mode_next == RPO_PRELOAD;
			clear_busy <= mode_next == RPO_CLEAR;
		end
	end

	// Clear lasts exactly the interval, then leaves
	clear_length_a: assert property ( // RULE6
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && mode_reg == RPO_CLEAR && clr_cnt_reg == `RPO_CNT_LAST)
		|=> mode_reg == RPO_RUN)
		else $error("clear did not end on time");

	// Fuse keeps test modes out
	fuse_blocks_a: assert property ( // RULE11
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && fuse_s) |=> !(mode_reg inside {RPO_PRELOAD, RPO_OBSERVE}))
		else $error("test mode entered with fuse set");

	// Fuse forces verify data programmed
	verify_lock_a: assert property ( // RULE10
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && fuse_s) |=> verify_data_out == `RPO_VERIFY_PROGRAMMED)
		else $error("verify data leaked");

	// Preload needs the mode lead
	preload_entry_a: assert property ( // RULE2
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && mode_reg != RPO_CLEAR && !smp_s) |=>
		mode_reg != RPO_PRELOAD)
		else $error("preload without mode lead");

	// Strobe loads odd pin levels into selected first cells, rest held
	preload_data_a: assert property ( // RULE1 RULE3 RULE4
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && load_pulse && !bank_s) |=>
		first_register == (($past(first_register) &
		~spread('1, $past(par_s))) |
		spread(odd_pins($past(pin_s)), $past(par_s))))
		else $error("first bank preload wrong");

	// Buried bank held across a first bank load
	preload_hold_a: assert property ( // RULE13
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && load_pulse && !bank_s) |=> $stable(buried_second_register))
		else $error("unselected bank changed");

	// No load without a fresh strobe edge
	strobe_edge_a: assert property ( // RULE14
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && mode_reg == RPO_PRELOAD && strobe_prev_reg) |=>
		$stable(first_register) && $stable(buried_second_register))
		else $error("load without strobe edge");

	// Observe shows buried bank
	observe_out_a: assert property ( // RULE5
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && mode_reg == RPO_OBSERVE) |=>
		io_pin_out == $past(buried_second_register))
		else $error("observe output wrong");

	// Cleared outputs follow polarity
	clear_polarity_a: assert property ( // RULE7
		@(posedge sys_clk) disable iff (!reset_n)
		(clk_en && mode_reg == RPO_CLEAR && first_register == '0) |=>
		io_pin_out == ~$past(pol_s))
		else $error("cleared output polarity wrong");
endmodule

// ---- hdl/rpo_consts.svh ----
/*
 Constants of the register preload and observe block: macrocell counts,
 verify word width and value, and power-up clear timing.
 Assumes a 50 MHz sys_clk and is included by the package and the top.
*/
// How it works
// RULE1 - Preload forces each selected register to the odd pin level, ignoring polarity.
// RULE2 - Preload state only while the mode lead holds the preload supervoltage.
// RULE3 - A preload strobe pulse copies pin levels into the chosen register group.
// RULE4 - Each load writes 12 registers; bank and parity selects pick the group.
// RULE5 - Observe mode shows buried second registers on outputs while enabled.
// RULE6 - Power-up clears all registers; interval typically 600 ns, at most 1000 ns.
// RULE7 - After the clear, each output shows its polarity applied to zero.
// RULE8 - Outside logic meets setup times before raising any clock after clear.
// RULE9 - Outside logic keeps clocks stable during the power-up clear interval.
// RULE10 - With the security fuse set, verify reads return all programmed.
// RULE11 - The security fuse disables both preload and buried observe mode.
// RULE12 - The programmer should set the security fuse last.
// RULE13 - Registers outside the selected group keep their contents.
// RULE14 - Preload acts only on the strobe rising edge, apart from functional clocks.
`ifndef RPO_CONSTS_SVH
`define RPO_CONSTS_SVH
`define RPO_NUM_CELLS 24
`define RPO_NUM_GROUP 12
`define RPO_CLK_PERIOD_NS 20
`define RPO_PR_TYP_NS 600
`define RPO_PR_MAX_NS 1000
// Longest time: rounded down to whole cycles
`define RPO_PR_CYCLES (`RPO_PR_MAX_NS / `RPO_CLK_PERIOD_NS)
// Last count of the clear counter, at the counter's width
`define RPO_CNT_LAST 6'(`RPO_PR_CYCLES - 1)
`define RPO_PR_CNT_W 6
`define RPO_VERIFY_W 8
`define RPO_VERIFY_PROGRAMMED 8'h00
`endif

// ---- hdl/rpo_pkg.sv ----
/*
 Types of the register preload and observe block.
 Assumes rpo_consts.svh is on the include path.
*/
`include "rpo_consts.svh"
package rpo_pkg;
	typedef logic [`RPO_NUM_CELLS-1:0] rpo_cells_t;
	typedef logic [`RPO_NUM_GROUP-1:0] rpo_group_t;
	typedef logic [`RPO_VERIFY_W-1:0] rpo_verify_t;
	typedef enum logic [1:0] {
		RPO_CLEAR,
		RPO_RUN,
		RPO_PRELOAD,
		RPO_OBSERVE
	} rpo_mode_t;
endpackage

// ---- hdl/rpo_sync.sv ----
/*
 Two flip-flop synchroniser for a group of pin levels.
 Assumes the inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module rpo_sync #(
	parameter int WIDTH = 1
) (
	// Clocking
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage is read only by the second
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ---- verification/rpo_programmer.sv ----
/*
 Programmer model: drives the mode leads, selects, strobe, pins and fuse.
 Assumes it shares sys_clk with the bench and is driven through its tasks.
*/
`timescale 1ns/1ps
module rpo_programmer (
	// Clock
	input wire logic sys_clk,
	// Test pins
	output logic special_mode_lead,
	output logic observe_mode_lead,
	output logic preload_strobe,
	output logic bank_select,
	output logic parity_select,
	output rpo_pkg::rpo_cells_t io_pin_in,
	output logic security_fuse
);
	import rpo_pkg::*;

	// Idle levels at time zero
	initial begin
		special_mode_lead = 1'h0;
		observe_mode_lead = 1'h0;
		preload_strobe = 1'h0;
		bank_select = 1'h0;
		parity_select = 1'h0;
		io_pin_in = 24'h000000;
		security_fuse = 1'h0;
	end

	// One load: lead up 4 cycles before the strobe, pins held past it
	task automatic preload(input logic mode, input logic bank,
		input logic par, input rpo_cells_t pins);
		@(posedge sys_clk);
		special_mode_lead <= mode;
		bank_select <= bank;
		parity_select <= par;
		io_pin_in <= pins;
		repeat (4) @(posedge sys_clk);
		preload_strobe <= 1'h1;
		repeat (3) @(posedge sys_clk);
		preload_strobe <= 1'h0;
		repeat (6) @(posedge sys_clk);
		special_mode_lead <= 1'h0;
		io_pin_in <= ~pins; // Released pins must not keep the old level
		repeat (3) @(posedge sys_clk);
	endtask

	// Mode lead alone, for watching the preload state itself
	task automatic mode_lead(input logic mode);
		@(posedge sys_clk);
		special_mode_lead <= mode;
	endtask

	// Observe lead and fuse; the bench sets the fuse after the preload and observe tests
	task automatic levels(input logic obs, input logic fuse);
		@(posedge sys_clk);
		observe_mode_lead <= obs;
		security_fuse <= fuse;
	endtask
endmodule

// ---- verification/register_preload_observe_test.sv ----
/*
 Self-checking bench for rpo_top with the programmer model.
 Assumes the design files and rpo_programmer are compiled first.
*/
`timescale 1ns/1ps
module register_preload_observe_test;
	import rpo_pkg::*;
	typedef struct packed {
		logic mode;
		logic bank;
		logic par;
		rpo_cells_t pins;
		rpo_cells_t first;
		rpo_cells_t buried;
	} rpo_row_t;
	rpo_row_t rows [6];
	logic sys_clk, reset_n, func_clk_en, preload_active, clear_busy;
	logic clk_en;
	logic special_mode_lead, observe_mode_lead, preload_strobe;
	logic bank_select, parity_select, security_fuse;
	rpo_cells_t io_pin_in, first_register_d, buried_second_register_d;
	rpo_cells_t out_polarity_high, out_enable_in, io_pin_out, io_pin_oe;
	rpo_cells_t first_register, buried_second_register;
	rpo_verify_t verify_data_in, verify_data_out;
	int n_tests = 0;
	int failures = 0;
	int n;

	rpo_programmer u_prog (.sys_clk(sys_clk),
		.special_mode_lead(special_mode_lead),
		.observe_mode_lead(observe_mode_lead),
		.preload_strobe(preload_strobe), .bank_select(bank_select),
		.parity_select(parity_select), .io_pin_in(io_pin_in),
		.security_fuse(security_fuse));

	rpo_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.special_mode_lead(special_mode_lead),
		.observe_mode_lead(observe_mode_lead),
		.preload_strobe(preload_strobe), .bank_select(bank_select),
		.parity_select(parity_select), .io_pin_in(io_pin_in),
		.security_fuse(security_fuse), .func_clk_en(func_clk_en),
		.first_register_d(first_register_d),
		.buried_second_register_d(buried_second_register_d),
		.out_polarity_high(out_polarity_high),
		.out_enable_in(out_enable_in), .verify_data_in(verify_data_in),
		.verify_data_out(verify_data_out), .io_pin_out(io_pin_out),
		.io_pin_oe(io_pin_oe), .first_register(first_register),
		.buried_second_register(buried_second_register),
		.preload_active(preload_active), .clear_busy(clear_busy));

	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	// Compare and count
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("%0d checks, %0d mismatches", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Bounded wait for the power-up clear to finish
	task automatic wait_clear();
		n = 0;
		while (clear_busy !== 1'h0 && n < 200) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 200) begin
			failures++;
			complete_run();
		end
	endtask

	// Hang guard
	initial begin
		#100000;
		failures++;
		complete_run();
	end

	// Main sequence
	initial begin
		rows = '{'{1'h1, 1'h0, 1'h0, 24'hAAAAAA, 24'h555555, 24'h000000},
			'{1'h1, 1'h1, 1'h1, 24'hAAAAAA, 24'h555555, 24'hAAAAAA},
			'{1'h1, 1'h0, 1'h1, 24'h00000A, 24'h55555F, 24'hAAAAAA},
			'{1'h1, 1'h1, 1'h0, 24'hA00000, 24'h55555F, 24'hFAAAAA},
			'{1'h1, 1'h0, 1'h0, 24'h555555, 24'h00000A, 24'hFAAAAA},
			'{1'h0, 1'h0, 1'h0, 24'hFFFFFF, 24'h00000A, 24'hFAAAAA}};
		sys_clk = 1'h0;
		reset_n = 1'h0;
		clk_en = 1'h1;
		func_clk_en = 1'h0;
		first_register_d = 24'h123456;
		buried_second_register_d = 24'h654321;
		out_polarity_high = 24'hF0F0F0;
		out_enable_in = 24'hFFFFFF;
		verify_data_in = 8'hC3;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'h1;
		wait_clear();
		check({23'h000000, n > 0 && n <= 50}, 24'h000001);
		repeat (4) @(posedge sys_clk);
		check(first_register, 24'h000000);
		check(buried_second_register, 24'h000000);
		check(io_pin_out, 24'h0F0F0F);
		check({16'h0000, verify_data_out}, 24'h0000C3);
		$display("power-up clear test done");
		out_polarity_high <= 24'h123456; // Must not affect loaded levels
		for (int i = 0; i < 6; i++) begin
			u_prog.preload(rows[i].mode, rows[i].bank, rows[i].par,
				rows[i].pins);
			check(first_register, rows[i].first);
			check(buried_second_register, rows[i].buried);
		end
		$display("preload rows test done");
		// Functional update only once the clear is long over
		func_clk_en <= 1'h1;
		@(posedge sys_clk);
		func_clk_en <= 1'h0;
		out_polarity_high <= 24'hFFFFFF;
		out_enable_in <= 24'h00FFFF;
		repeat (2) @(posedge sys_clk);
		check(first_register, 24'h123456);
		u_prog.levels(1'h1, 1'h0);
		repeat (6) @(posedge sys_clk);
		check(io_pin_out, 24'h654321);
		check(io_pin_oe, 24'h00FFFF);
		u_prog.levels(1'h0, 1'h0);
		repeat (6) @(posedge sys_clk);
		check(io_pin_out, 24'h123456);
		$display("observe test done");
		u_prog.mode_lead(1'h1);
		repeat (5) @(posedge sys_clk);
		check({23'h000000, preload_active}, 24'h000001);
		check(io_pin_oe, 24'h000000);
		u_prog.mode_lead(1'h0);
		repeat (5) @(posedge sys_clk);
		check({23'h000000, preload_active}, 24'h000000);
		check(io_pin_oe, 24'h00FFFF);
		$display("preload state test done");
		u_prog.levels(1'h1, 1'h1);
		u_prog.preload(1'h1, 1'h0, 1'h0, 24'hFFFFFF);
		check(first_register, 24'h123456);
		check(io_pin_out, 24'h123456);
		check({16'h0000, verify_data_out}, 24'h000000);
		$display("security fuse test done");
		// Clock enable low freezes the functional update too
		clk_en <= 1'h0;
		first_register_d <= 24'hABCDEF;
		func_clk_en <= 1'h1;
		repeat (3) @(posedge sys_clk);
		check(first_register, 24'h123456);
		clk_en <= 1'h1;
		@(posedge sys_clk);
		func_clk_en <= 1'h0;
		repeat (2) @(posedge sys_clk);
		check(first_register, 24'hABCDEF);
		$display("clock enable test done");
		u_prog.levels(1'h0, 1'h0);
		reset_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		check(first_register, 24'h000000);
		check({23'h000000, clear_busy}, 24'h000001);
		reset_n <= 1'h1;
		u_prog.preload(1'h1, 1'h0, 1'h0, 24'hFFFFFF);
		wait_clear();
		repeat (4) @(posedge sys_clk);
		check(first_register, 24'h000000);
		$display("second reset test done");
		complete_run();
	end
endmodule
